// ==== rtl/status_pin_function_mux.sv ====
// eight-pin function multiplexer with flag combining and its registers
`timescale 1ns/1ps

// Function
// - code zero puts pin in analog shutdown
// - codes one, two drive constant low, high
// - code three outputs current dac clock
// - code five input requests mute of all
// - code six input controls system mode
// - code eight outputs per-sample clock strobe
// - codes nine, ten output frame, bitstream valid
// - code eleven outputs serial clock monitor fail
// - codes twelve to fourteen output combined flags
// - pin one automute, others shutdown at reset
// - output enable clear tristates; reset clear on pins two-eight
// - pin one output enable resets set
// - input enable bit gates pin receiver
// - input enables reset set on pins three-five
// - mode input high: power down or high_fidelity_operation
// - mode input low follows path enable bit
// - channel select picks channel value plus one
// - or combine wins over and, select
// - ramp flag: and of all, else selected
// - min, automute: and of all, else selected
// - path enable bit gates data path, resets zero
module status_pin_function_mux
   import pin_mux_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // control port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // pads
   input wire logic [7:0] pin_level_in,
   output logic [7:0] pin_drive_out,
   output logic [7:0] pin_drive_oe_out,
   output logic [7:0] pin_shutdown_out,
   output logic [7:0] pin_rx_enable_out,
   // signal sources
   input wire logic current_dac_clock_in,
   input wire logic per_sample_clock_strobe_in,
   input wire logic frame_valid_in,
   input wire logic packed_bitstream_locked_in,
   input wire logic serial_clock_monitor_fail_in,
   input wire logic [7:0] min_level_flag_in,
   input wire logic [7:0] automute_flag_in,
   input wire logic [7:0] ramp_done_flag_in,
   // system controls
   output logic mute_all_out,
   output logic power_down_out,
   output logic high_fidelity_operation_out,
   output logic data_path_enable_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] func;
      logic [7:0] oe;
      logic [7:0] ie;
      logic [15:0] combine;
      logic [7:0] wr_shadow;
      logic [7:0] rd_shadow;
      logic path_en;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] drive;
      logic [7:0] drive_oe;
      logic [7:0] shutdown;
      logic mute;
      logic power_down;
      logic high_fidelity_operation;
      logic [7:0] rdata;
   } state_t;

   localparam state_t STATE_RST = '{
      func: FUNC_RST, oe: OE_RST, ie: IE_RST, combine: COMBINE_RST,
      wr_shadow: 8'h00, rd_shadow: 8'h00, path_en: PATH_EN_RST,
      sync1: 8'h00, sync2: 8'h00, drive: 8'h00, drive_oe: OE_RST,
      shutdown: 8'hfe, mute: 1'b0, power_down: 1'b0, high_fidelity_operation: 1'b0,
      rdata: 8'h00};

   state_t cur;
   state_t nxt;

   // ----------------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------------
   // codes that turn the pad into a driver; reserved codes are not among them
   function automatic logic is_output_code(input logic [3:0] code);
      unique case (code)
         FN_DRIVE_LOW, FN_DRIVE_HIGH, FN_DAC_CLOCK, FN_SAMPLE_STROBE,
         FN_FRAME_VALID, FN_BITSTREAM_VALID, FN_CLOCK_FAIL,
         FN_MIN_LEVEL, FN_AUTOMUTE, FN_RAMP_DONE: is_output_code = 1'b1;
         default: is_output_code = 1'b0;
      endcase
   endfunction

   // or of all wins, then and of all, then the selected channel
   function automatic logic pick_flag(input logic [7:0] flags, input logic any_b,
                                      input logic all_b, input logic [2:0] sel);
      if (any_b) begin
         pick_flag = |flags;
      end else if (all_b) begin
         pick_flag = &flags;
      end else begin
         pick_flag = flags[sel];
      end
   endfunction

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   // all outputs are registered, so pads follow sources one clock late;
   // the routed dac clock must therefore be well below half of mclk
   always_comb begin
      logic [2:0] sel;
      logic min_flag;
      logic mute_flag;
      logic ramp_flag;
      logic [3:0] code;
      logic value;
      logic [7:0] rx;
      logic mode_hit;
      logic mute_hit;
      sel = 3'd0;
      min_flag = 1'b0;
      mute_flag = 1'b0;
      ramp_flag = 1'b0;
      code = 4'h0;
      value = 1'b0;
      rx = 8'h00;
      mode_hit = 1'b0;
      mute_hit = 1'b0;
      nxt = cur;
      // first stage feeds only the second
      nxt.sync1 = pin_level_in;
      nxt.sync2 = cur.sync1;
      rx = cur.sync2 & cur.ie;
      sel = cur.combine[SEL_LSB +: 3];
      min_flag = pick_flag(min_level_flag_in, cur.combine[OR_MIN_LEVEL_BIT],
                           cur.combine[AND_MIN_LEVEL_BIT], sel);
      mute_flag = pick_flag(automute_flag_in, cur.combine[OR_AUTOMUTE_BIT],
                            cur.combine[AND_AUTOMUTE_BIT], sel);
      ramp_flag = pick_flag(ramp_done_flag_in, cur.combine[OR_RAMP_BIT],
                            cur.combine[AND_RAMP_BIT], sel);
      // per-pin function decode
      for (int i = 0; i < 8; i++) begin
         code = cur.func[i*4 +: 4];
         unique case (code)
            FN_DRIVE_HIGH: value = 1'b1;
            FN_DAC_CLOCK: value = current_dac_clock_in;
            FN_SAMPLE_STROBE: value = per_sample_clock_strobe_in;
            FN_FRAME_VALID: value = frame_valid_in;
            FN_BITSTREAM_VALID: value = packed_bitstream_locked_in;
            FN_CLOCK_FAIL: value = serial_clock_monitor_fail_in;
            FN_MIN_LEVEL: value = min_flag;
            FN_AUTOMUTE: value = mute_flag;
            FN_RAMP_DONE: value = ramp_flag;
            default: value = 1'b0;
         endcase
         nxt.drive_oe[i] = is_output_code(code) & cur.oe[i];
         nxt.drive[i] = value & nxt.drive_oe[i];
         nxt.shutdown[i] = (code == FN_SHUTDOWN);
         mute_hit = mute_hit | ((code == FN_MUTE_IN) & rx[i]);
         mode_hit = mode_hit | ((code == FN_MODE_IN) & rx[i]);
      end
      nxt.mute = mute_hit;
      // a high mode pin overrides; a low one hands control to the path bit
      if (mode_hit) begin
         nxt.power_down = ~cur.combine[MODE_POLARITY_BIT];
         nxt.high_fidelity_operation = cur.combine[MODE_POLARITY_BIT];
      end else begin
         nxt.power_down = 1'b0;
         nxt.high_fidelity_operation = cur.path_en;
      end
      // register writes; the wide register commits on its upper byte
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            SYS_CONFIG_ADDR: nxt.path_en = reg_wdata_in[PATH_EN_BIT];
            PIN_FUNC_A_ADDR: nxt.func[7:0] = reg_wdata_in;
            PIN_FUNC_B_ADDR: nxt.func[15:8] = reg_wdata_in;
            PIN_FUNC_C_ADDR: nxt.func[23:16] = reg_wdata_in;
            PIN_FUNC_D_ADDR: nxt.func[31:24] = reg_wdata_in;
            PIN_OE_ADDR: nxt.oe = reg_wdata_in;
            PIN_IE_ADDR: nxt.ie = reg_wdata_in;
            COMBINE_LO_ADDR: nxt.wr_shadow = reg_wdata_in;
            COMBINE_HI_ADDR: nxt.combine = {reg_wdata_in, cur.wr_shadow} & COMBINE_WRITABLE;
            default: nxt.path_en = cur.path_en;
         endcase
      end
      // register reads; the upper byte is frozen when the lower is read
      nxt.rdata = 8'h00;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            SYS_CONFIG_ADDR: nxt.rdata[PATH_EN_BIT] = cur.path_en;
            PIN_FUNC_A_ADDR: nxt.rdata = cur.func[7:0];
            PIN_FUNC_B_ADDR: nxt.rdata = cur.func[15:8];
            PIN_FUNC_C_ADDR: nxt.rdata = cur.func[23:16];
            PIN_FUNC_D_ADDR: nxt.rdata = cur.func[31:24];
            PIN_OE_ADDR: nxt.rdata = cur.oe;
            PIN_IE_ADDR: nxt.rdata = cur.ie;
            COMBINE_LO_ADDR: begin
               nxt.rdata = cur.combine[7:0];
               nxt.rd_shadow = cur.combine[15:8];
            end
            COMBINE_HI_ADDR: nxt.rdata = cur.rd_shadow;
            default: nxt.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cur <= STATE_RST;
      end else begin
         cur <= nxt;
      end
   end

   // outputs taken straight from the state register
   assign reg_rdata_out = cur.rdata;
   assign pin_drive_out = cur.drive;
   assign pin_drive_oe_out = cur.drive_oe;
   assign pin_shutdown_out = cur.shutdown;
   assign pin_rx_enable_out = cur.ie;
   assign mute_all_out = cur.mute;
   assign power_down_out = cur.power_down;
   assign high_fidelity_operation_out = cur.high_fidelity_operation;
   assign data_path_enable_out = cur.path_en;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   sequence mute_request;
      cur.func[11:8] == FN_MUTE_IN && cur.ie[2] && cur.sync2[2];
   endsequence
   sequence mode_high;
      cur.func[15:12] == FN_MODE_IN && cur.ie[3] && cur.sync2[3];
   endsequence

   a_shutdown_code: assert property (
      cur.func[7:4] == FN_SHUTDOWN |=> pin_shutdown_out[1] && !pin_drive_oe_out[1])
      else $error("shutdown pin not quiet");
   a_drive_low: assert property (
      cur.func[7:4] == FN_DRIVE_LOW && cur.oe[1] |=> pin_drive_oe_out[1] && !pin_drive_out[1])
      else $error("constant low not driven");
   a_dac_clock: assert property (
      cur.func[7:4] == FN_DAC_CLOCK && cur.oe[1] |=> pin_drive_out[1] == $past(current_dac_clock_in))
      else $error("dac clock not routed");
   a_mute_request: assert property (mute_request |=> mute_all_out)
      else $error("mute request lost");
   a_mode_override: assert property (
      mode_high |=> power_down_out == !$past(cur.combine[MODE_POLARITY_BIT])
                    && high_fidelity_operation_out == $past(cur.combine[MODE_POLARITY_BIT]))
      else $error("mode pin not obeyed");
   a_strobe_route: assert property (
      cur.func[7:4] == FN_SAMPLE_STROBE && cur.oe[1]
      |=> pin_drive_out[1] == $past(per_sample_clock_strobe_in))
      else $error("sample strobe not routed");
   a_flag_any: assert property (
      cur.func[3:0] == FN_RAMP_DONE && cur.oe[0] && cur.combine[OR_RAMP_BIT]
      |=> pin_drive_out[0] == |$past(ramp_done_flag_in))
      else $error("or combine wrong");
   a_flag_select: assert property (
      cur.func[3:0] == FN_MIN_LEVEL && cur.oe[0] && cur.combine[5:0] == 6'h00
      |=> pin_drive_out[0] == $past(min_level_flag_in[cur.combine[8:6]]))
      else $error("channel select wrong");
   a_reserved_quiet: assert property (
      cur.func[7:4] == 4'h7 |=> !pin_drive_oe_out[1] && !pin_drive_out[1])
      else $error("reserved code drives");
   a_oe_gate: assert property (!cur.oe[1] |=> !pin_drive_oe_out[1])
      else $error("pad driven without enable");
   a_path_write: assert property (
      reg_wr_in && reg_addr_in == SYS_CONFIG_ADDR
      |=> data_path_enable_out == $past(reg_wdata_in[PATH_EN_BIT]))
      else $error("path enable not stored");
   a_reset_defaults: assert property (
      @(posedge mclk_in) disable iff (1'b0)
      !rst_n_in |=> pin_drive_oe_out == OE_RST && pin_rx_enable_out == IE_RST)
      else $error("reset defaults wrong");
   a_reset_quiet: assert property (
      @(posedge mclk_in) disable iff (1'b0)
      !rst_n_in |=> pin_shutdown_out == 8'hfe && !mute_all_out && !power_down_out)
      else $error("reset state not quiet");
   // a mute needs some enabled receiver that read high one cycle before
   a_mute_source: assert property (mute_all_out |-> $past(|(cur.ie & cur.sync2)))
      else $error("mute without enabled input");
   a_flag_all: assert property (
      cur.func[3:0] == FN_AUTOMUTE && cur.oe[0] && !cur.combine[OR_AUTOMUTE_BIT]
      && cur.combine[AND_AUTOMUTE_BIT] |=> pin_drive_out[0] == &$past(automute_flag_in))
      else $error("and combine wrong");

endmodule

// ==== rtl/pin_mux_pkg.sv ====
// constants for the status pin function multiplexer
package pin_mux_pkg;

   // ----------------------------------------------------------------------
   // register offsets on the control port
   // ----------------------------------------------------------------------
   localparam logic [7:0] SYS_CONFIG_ADDR = 8'h00;
   localparam logic [7:0] PIN_FUNC_A_ADDR = 8'h10;
   localparam logic [7:0] PIN_FUNC_B_ADDR = 8'h11;
   localparam logic [7:0] PIN_FUNC_C_ADDR = 8'h12;
   localparam logic [7:0] PIN_FUNC_D_ADDR = 8'h13;
   localparam logic [7:0] PIN_OE_ADDR = 8'h14;
   localparam logic [7:0] PIN_IE_ADDR = 8'h15;
   localparam logic [7:0] COMBINE_LO_ADDR = 8'h17;
   localparam logic [7:0] COMBINE_HI_ADDR = 8'h18;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int PATH_EN_BIT = 1;
   localparam int AND_AUTOMUTE_BIT = 0;
   localparam int AND_MIN_LEVEL_BIT = 1;
   localparam int AND_RAMP_BIT = 2;
   localparam int OR_AUTOMUTE_BIT = 3;
   localparam int OR_MIN_LEVEL_BIT = 4;
   localparam int OR_RAMP_BIT = 5;
   localparam int SEL_LSB = 6;
   localparam int MODE_POLARITY_BIT = 15;
   localparam logic [15:0] COMBINE_WRITABLE = 16'h81ff;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [31:0] FUNC_RST = 32'h0000_000d;
   localparam logic [7:0] OE_RST = 8'h01;
   localparam logic [7:0] IE_RST = 8'h1c;
   localparam logic [15:0] COMBINE_RST = 16'h0007;
   localparam logic PATH_EN_RST = 1'b0;

   // ----------------------------------------------------------------------
   // pin function codes
   // ----------------------------------------------------------------------
   localparam logic [3:0] FN_SHUTDOWN = 4'h0;
   localparam logic [3:0] FN_DRIVE_LOW = 4'h1;
   localparam logic [3:0] FN_DRIVE_HIGH = 4'h2;
   localparam logic [3:0] FN_DAC_CLOCK = 4'h3;
   localparam logic [3:0] FN_MUTE_IN = 4'h5;
   localparam logic [3:0] FN_MODE_IN = 4'h6;
   localparam logic [3:0] FN_SAMPLE_STROBE = 4'h8;
   localparam logic [3:0] FN_FRAME_VALID = 4'h9;
   localparam logic [3:0] FN_BITSTREAM_VALID = 4'ha;
   localparam logic [3:0] FN_CLOCK_FAIL = 4'hb;
   localparam logic [3:0] FN_MIN_LEVEL = 4'hc;
   localparam logic [3:0] FN_AUTOMUTE = 4'hd;
   localparam logic [3:0] FN_RAMP_DONE = 4'he;

endpackage

// ==== rtl/README_unused.sv ====
// holds no logic; the whole block lives in status_pin_function_mux.sv

// ==== test/pin_board_model.sv ====
// board-side model of the eight status pads
`timescale 1ns/1ps
module pin_board_model (
   // pad side of the device
   input wire logic [7:0] pin_drive_in,
   input wire logic [7:0] pin_drive_oe_in,
   // levels the board applies to pads it owns
   input wire logic [7:0] board_level_in,
   // resolved pad levels
   output logic [7:0] pin_level_out
);
   // a driven pad shows the device value; an undriven one shows the board,
   // which is how mute and mode requests reach the device
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_level_out[i] = pin_drive_oe_in[i] ? pin_drive_in[i] : board_level_in[i];
      end
   end
endmodule

// ==== test/status_pin_function_mux_tb.sv ====
// self-checking bench for the status pin function multiplexer
`timescale 1ns/1ps
module status_pin_function_mux_tb;
   import pin_mux_pkg::*;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out, pin_level_in, pin_drive_out, pin_drive_oe_out;
   logic [7:0] pin_shutdown_out, pin_rx_enable_out;
   logic [7:0] board_level = 8'h00;
   logic [4:0] src = 5'h00;
   logic [7:0] fl [3];
   logic mute_all_out, power_down_out, high_fidelity_operation_out, data_path_enable_out;
   int errors = 0;
   int n_compared = 0;

   // 50 MHz system clock
   always #10 mclk_in = ~mclk_in;

   status_pin_function_mux dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .pin_level_in(pin_level_in), .pin_drive_out(pin_drive_out),
      .pin_drive_oe_out(pin_drive_oe_out), .pin_shutdown_out(pin_shutdown_out),
      .pin_rx_enable_out(pin_rx_enable_out),
      .current_dac_clock_in(src[0]), .per_sample_clock_strobe_in(src[1]),
      .frame_valid_in(src[2]), .packed_bitstream_locked_in(src[3]),
      .serial_clock_monitor_fail_in(src[4]),
      .min_level_flag_in(fl[0]), .automute_flag_in(fl[1]), .ramp_done_flag_in(fl[2]),
      .mute_all_out(mute_all_out), .power_down_out(power_down_out),
      .high_fidelity_operation_out(high_fidelity_operation_out),
      .data_path_enable_out(data_path_enable_out)
   );

   pin_board_model board (
      .pin_drive_in(pin_drive_out), .pin_drive_oe_in(pin_drive_oe_out),
      .board_level_in(board_level), .pin_level_out(pin_level_in)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // strobes rise at a falling edge and drop one cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
   endtask

   // read data stands for one cycle only, so it is taken at once
   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge mclk_in);
      reg_rd_in = 1'b0;
      check({8'h00, reg_rdata_out}, {8'h00, exp});
   endtask

   // covers the register stage plus the two-flop pad synchroniser
   task automatic settle;
      repeat (4) @(negedge mclk_in);
   endtask

   task automatic report_and_stop;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic reset_values;
      check({8'h00, pin_drive_oe_out}, 16'h0001);
      check({8'h00, pin_shutdown_out}, 16'h00fe);
      check({8'h00, pin_rx_enable_out}, 16'h001c);
      check({15'h0000, pin_drive_out[0]}, 16'h0001);
      rd_check(PIN_FUNC_A_ADDR, 8'h0d);
      for (int a = 8'h11; a <= 8'h13; a++) begin
         rd_check(8'(a), 8'h00);
      end
      rd_check(PIN_OE_ADDR, 8'h01);
      rd_check(PIN_IE_ADDR, 8'h1c);
      rd_check(COMBINE_LO_ADDR, 8'h07);
      rd_check(COMBINE_HI_ADDR, 8'h00);
      rd_check(SYS_CONFIG_ADDR, 8'h00);
      rd_check(8'h16, 8'h00);
   endtask

   // pin two: expect {drive, enable, shutdown}
   task automatic out_case(input logic [3:0] code, input logic [4:0] s, input logic [2:0] e);
      src = s;
      wr(PIN_FUNC_A_ADDR, {code, 4'hd});
      settle();
      check({13'h0000, pin_drive_out[1], pin_drive_oe_out[1], pin_shutdown_out[1]},
         {13'h0000, e});
   endtask

   task automatic output_codes;
      logic [3:0] srcs [5] = '{4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
      logic [3:0] resv [3] = '{4'h4, 4'h7, 4'hf};
      wr(PIN_OE_ADDR, 8'h03);
      out_case(4'h0, 5'h1f, 3'h1);
      out_case(4'h1, 5'h1f, 3'h2);
      out_case(4'h2, 5'h00, 3'h6);
      for (int i = 0; i < 5; i++) begin
         out_case(srcs[i], 5'(1 << i), 3'h6);
         out_case(srcs[i], ~5'(1 << i), 3'h2);
      end
      for (int i = 0; i < 3; i++) begin
         out_case(resv[i], 5'h1f, 3'h0);
      end
      wr(PIN_OE_ADDR, 8'h01);
      out_case(4'h2, 5'h1f, 3'h0);
   endtask

   // pin one carries flag type k; the other two types see the inverse
   task automatic flag_case(input int k, input logic [7:0] lo, input logic [7:0] hi,
      input logic [7:0] v, input logic e);
      fl[0] = ~v;
      fl[1] = ~v;
      fl[2] = ~v;
      fl[k] = v;
      wr(COMBINE_LO_ADDR, lo);
      wr(COMBINE_HI_ADDR, hi);
      wr(PIN_FUNC_A_ADDR, 8'h0c + 8'(k));
      settle();
      check({15'h0000, pin_drive_out[0]}, {15'h0000, e});
   endtask

   task automatic flag_combine;
      int ab;
      for (int k = 0; k < 3; k++) begin
         ab = (k == 0) ? 1 : (k == 1) ? 0 : 2;
         flag_case(k, 8'(1 << ab), 8'h00, 8'hfe, 1'b0);
         flag_case(k, 8'(1 << ab), 8'h00, 8'hff, 1'b1);
         flag_case(k, 8'(9 << ab), 8'h00, 8'h10, 1'b1);
         flag_case(k, 8'hc0, 8'h01, 8'h80, 1'b1);
         flag_case(k, 8'hc0, 8'h01, 8'h7f, 1'b0);
         flag_case(k, 8'h40, 8'h00, 8'h02, 1'b1);
      end
   endtask

   task automatic mute_input;
      wr(PIN_FUNC_B_ADDR, 8'h05);
      board_level = 8'h04;
      settle();
      check({15'h0000, mute_all_out}, 16'h0001);
      wr(PIN_IE_ADDR, 8'h18);
      settle();
      check({15'h0000, mute_all_out}, 16'h0000);
      board_level = 8'h00;
      wr(PIN_IE_ADDR, 8'h1c);
   endtask

   // expect {power down, high fidelity, path enable}
   task automatic mode_input;
      wr(PIN_FUNC_B_ADDR, 8'h60);
      board_level = 8'h08;
      settle();
      check({13'h0000, power_down_out, high_fidelity_operation_out, data_path_enable_out},
         16'h0004);
      wr(COMBINE_LO_ADDR, 8'h07);
      wr(COMBINE_HI_ADDR, 8'h80);
      rd_check(COMBINE_LO_ADDR, 8'h07);
      rd_check(COMBINE_HI_ADDR, 8'h80);
      settle();
      check({13'h0000, power_down_out, high_fidelity_operation_out, data_path_enable_out},
         16'h0002);
      board_level = 8'h00;
      wr(SYS_CONFIG_ADDR, 8'h02);
      rd_check(SYS_CONFIG_ADDR, 8'h02);
      settle();
      check({13'h0000, power_down_out, high_fidelity_operation_out, data_path_enable_out},
         16'h0003);
      wr(SYS_CONFIG_ADDR, 8'h00);
      settle();
      check({13'h0000, power_down_out, high_fidelity_operation_out, data_path_enable_out},
         16'h0000);
   endtask

   // main sequence; automute flags start all set so pin one drives high
   initial begin
      fl[0] = 8'h00;
      fl[1] = 8'hff;
      fl[2] = 8'h00;
      repeat (10) @(negedge mclk_in);
      rst_n_in = 1'b1;
      @(negedge mclk_in);
      reset_values();
      output_codes();
      flag_combine();
      mute_input();
      mode_input();
      report_and_stop();
   end

   // watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #(20 * 5000);
      errors++;
      report_and_stop();
   end
endmodule
